// File: tb/spl_array_model.sv
/* Data array model answering the page read port.
   Assumes the registered read of one system clock. */
`default_nettype none
module spl_array_model
(
   input  wire logic       sys_clk,
   input  wire logic       page_rd_en,
   input  wire logic [6:0] page_rd_addr,
   output logic [7:0]      page_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // Registered read port.
   // ********
   initial page_rd_data = 8'h00;
   // Idle cycles toggle the data, so stale bytes never match by luck.
   always @(posedge sys_clk)
      if (page_rd_en)
         page_rd_data <= {page_rd_addr, 1'b1} ^ 8'h96;
      else
         page_rd_data <= ~page_rd_data;
endmodule // spl_array_model
`default_nettype wire

// File: tb/spl_page_lock_sva.sv
/* Checker for the page-lock block, bound to its top ports.
   Assumes the bound instance passes its PROG_CYCLES on. */
`default_nettype none
module spl_page_lock_sva #(parameter int PROG_CYCLES = 60)
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        spi_cs_n,
   input wire logic        spi_so_oe_n,
   input wire logic        wp_n,
   input wire logic        write_latch,
   input wire logic        block_guard_bit_low,
   input wire logic        block_guard_bit_high,
   input wire logic        page_rd_en,
   input wire logic [6:0]  page_rd_addr,
   input wire logic        busy,
   input wire logic        lock_update_success_flag,
   input wire logic        write_latch_clear,
   input wire logic [15:0] lock_state
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // Relations in the system clock domain.
   // ********
   localparam int P_LO = PROG_CYCLES - 2;  // Slack for the handover.
   localparam int P_HI = PROG_CYCLES + 4;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_wen; $rose(busy) |-> write_latch && wp_n; endproperty
   a_wen: assert property (p_wen) else $error("lock accepted while disabled");
   property p_grd; $rose(page_rd_en) |-> !({block_guard_bit_high, block_guard_bit_low} == 2'h3 ||
      (block_guard_bit_high && page_rd_addr[6]) || (block_guard_bit_low && page_rd_addr[6:5] == 2'h3)); endproperty
   a_grd: assert property (p_grd) else $error("guarded page checked");
   property p_cs; $rose(busy) |-> spi_cs_n && $past(spi_cs_n, 3); endproperty
   a_cs: assert property (p_cs) else $error("busy before frame end");
   property p_base; $rose(page_rd_en) |-> page_rd_addr[2:0] == 3'h0; endproperty
   a_base: assert property (p_base) else $error("read not at page base");
   property p_inc; page_rd_en && $past(page_rd_en) |-> page_rd_addr == $past(page_rd_addr) + 7'h1; endproperty
   a_inc: assert property (p_inc) else $error("read address not ascending");
   property p_len; $rose(page_rd_en) |-> page_rd_en [*8] ##1 !page_rd_en; endproperty
   a_len: assert property (p_len) else $error("page read not eight bytes");
   property p_chg; $changed(lock_state) |-> $past(busy) && !lock_update_success_flag; endproperty
   a_chg: assert property (p_chg) else $error("lock change without success");
   property p_fell; $fell(lock_update_success_flag) |-> $fell(busy); endproperty
   a_fell: assert property (p_fell) else $error("flag cleared off cycle end");
   property p_prog; $rose(lock_update_success_flag) |-> ##[P_LO:P_HI] $fell(busy); endproperty
   a_prog: assert property (p_prog) else $error("programming time wrong");
   property p_wlc; write_latch_clear |-> busy && write_latch; endproperty
   a_wlc: assert property (p_wlc) else $error("latch clear off acceptance");
   property p_oe; spi_cs_n |-> spi_so_oe_n; endproperty
   a_oe: assert property (p_oe) else $error("output driven while deselected");
   c_prog: cover property ($fell(lock_update_success_flag));
   c_read: cover property ($rose(page_rd_en));
   c_query: cover property (!spi_so_oe_n);
endmodule // spl_page_lock_sva
`default_nettype wire

// File: tb/test_spl_page_lock.sv
/* Random bench for the page-lock block with corner cases.
   Assumes the array model and a serial clock run only in frames. */
`default_nettype none
module test_spl_page_lock import spl_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PROG = 60;  // Short cycle keeps the run brief.
   logic        sys_clk = 1'b0, rst = 1'b1, spi_sck = 1'b0, spi_cs_n = 1'b1, spi_si = 1'b0;
   logic        wp_n = 1'b1, wl = 1'b1, so, oe_n, rd_en, busy, flag, wlc, exp_flag;
   logic [1:0]  grd = 2'h0;
   logic [6:0]  rd_addr;
   logic [7:0]  rd_data;
   logic [15:0] lock, exp_lock;
   logic [31:0] seed = 32'hafd0fc40;
   int          err_total = 0, n_checks = 0, cyc = 0;
   initial forever #12.5 sys_clk = ~sys_clk;
   spl_page_lock #(.PROG_CYCLES(PROG)) dut_u (.sys_clk(sys_clk), .rst(rst), .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(so), .spi_so_oe_n(oe_n), .wp_n(wp_n),
      .write_latch(wl), .block_guard_bit_low(grd[0]), .block_guard_bit_high(grd[1]),
      .page_rd_en(rd_en), .page_rd_addr(rd_addr), .page_rd_data(rd_data), .busy(busy),
      .lock_update_success_flag(flag), .write_latch_clear(wlc), .lock_state(lock));
   spl_array_model mem_u (.sys_clk(sys_clk), .page_rd_en(rd_en), .page_rd_addr(rd_addr),
      .page_rd_data(rd_data));
   // ********
   // Helpers: random source, expected bytes and comparison.
   // ********
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [7:0] refb(logic [3:0] pg, logic [2:0] i);
      return {pg, i, 1'b1} ^ 8'h96;
   endfunction
   task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Master side: data changes with the clock low, sampled on its rise.
   task automatic xb(logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
      begin
         spi_si = b[i];
         #24 spi_sck = 1'b1;
         r = {r[6:0], so};
         #24 spi_sck = 1'b0;
      end
   endtask
   task automatic frame(logic [7:0] op, logic [3:0] pg, int n, int bad, int q);
      logic [7:0] r;
      @(negedge sys_clk) spi_cs_n = 1'b0;
      #60 xb(op, r);
      xb({1'b1, pg, 3'h0}, r);
      for (int i = 0; i < n; i++)
      begin
         xb(refb(pg, i[2:0]) ^ {7'h0, i == bad}, r);
         if (q == 1) chk("query", {8'h0, r}, {8'h0, exp_lock[pg + i[3:0]], 7'h0});
         if (q > 0) chk("so_oe_n", {15'h0, oe_n}, {15'h0, q == 2});
      end
      #60 spi_cs_n = 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic lk(logic [7:0] op, logic [3:0] pg, int n, int bad, int hit);
      logic ok;
      ok = wl && wp_n && !(grd == 2'h3 || (grd[1] && pg[3]) || (grd[0] && pg[3:2] == 2'h3)) && n == 8 && bad > 7;
      frame(op, pg, n, bad, 0);
      if (hit) frame(SPL_OP_LOCK_QUERY, pg, 1, 8, 2);
      for (int k = 0; k < 300 && busy !== 1'b0; k++) @(negedge sys_clk);
      @(negedge sys_clk);
      if (ok)
      begin
         exp_lock[pg] = (op == SPL_OP_LOCK_CLEAR);
         exp_flag = 1'b0;
      end
      chk("lock_state", lock, exp_lock);
      chk("flag", {15'h0, flag}, {15'h0, exp_flag});
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         err_total++;
         final_report();
      end
   end
   initial
   begin
      exp_lock = SPL_LOCK_RESET;
      exp_flag = SPL_FLAG_RESET;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk) rst = 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("reset", lock, exp_lock);
      lk(SPL_OP_LOCK_SET, 4'hf, 8, 8, 1);
      frame(SPL_OP_LOCK_QUERY, 4'hf, 3, 8, 1);
      for (int t = 0; t < 30; t++)
      begin
         seed = xs(seed);
         @(negedge sys_clk);
         wl = seed[0] | seed[1];
         wp_n = seed[2] | seed[3];
         grd = seed[5:4] & {2{seed[6]}};
         lk(seed[7] ? SPL_OP_LOCK_SET : SPL_OP_LOCK_CLEAR, seed[11:8], 8 + (seed[15:12] == 4'h0),
            (seed[18:16] == 3'h0) ? int'(seed[21:19]) : 8, 0);
      end
      frame(SPL_OP_LOCK_QUERY, seed[3:0], 17, 8, 1);
      final_report();
   end
endmodule // test_spl_page_lock
bind spl_page_lock spl_page_lock_sva #(.PROG_CYCLES(PROG_CYCLES)) sva_u (.sys_clk(sys_clk), .rst(rst),
   .spi_cs_n(spi_cs_n), .spi_so_oe_n(spi_so_oe_n), .wp_n(wp_n), .write_latch(write_latch),
   .block_guard_bit_low(block_guard_bit_low), .block_guard_bit_high(block_guard_bit_high),
   .page_rd_en(page_rd_en), .page_rd_addr(page_rd_addr), .busy(busy),
   .lock_update_success_flag(lock_update_success_flag), .write_latch_clear(write_latch_clear),
   .lock_state(lock_state));
`default_nettype wire

// File: verilog/spl_page_lock.sv
/*
 * Page-lock logic of a small serial EEPROM: serial command decoding for
 * the lock set, lock clear and lock query commands, the sixteen-bit lock
 * memory, reference data verification and the timed programming cycle.
 * Assumes: the data array answers page_rd_addr one system clock after
 * page_rd_en; write latch and block guard bits come from sys_clk logic;
 * the SPI master uses mode 0 and keeps its clock still outside frames.
 */
`default_nettype none

module spl_page_lock
   import spl_pkg::*;
#(
   parameter int PROG_CYCLES = spl_pkg::SPL_PROG_CYCLES  // Lock cycle length in sys_clk cycles.
)
(
   input  wire logic        sys_clk,                    // System clock, 40 MHz.
   input  wire logic        rst,                        // Asynchronous reset, active high.
   input  wire logic        spi_sck,                    // Serial clock from the master.
   input  wire logic        spi_cs_n,                   // Chip select, active low.
   input  wire logic        spi_si,                     // Serial data in.
   output logic             spi_so,                     // Serial data out.
   output logic             spi_so_oe_n,                // Serial out enable, low drives.
   input  wire logic        wp_n,                       // Write protect pin, active low.
   input  wire logic        write_latch,                // Write enable latch state.
   input  wire logic        block_guard_bit_low,        // Block guard status bit 0.
   input  wire logic        block_guard_bit_high,       // Block guard status bit 1.
   output logic             page_rd_en,                 // Data array read strobe.
   output logic [6:0]       page_rd_addr,               // Data array byte address.
   input  wire logic [7:0]  page_rd_data,               // Data array read data.
   output logic             busy,                       // Lock check or programming running.
   output logic             lock_update_success_flag,   // Low after a successful lock change.
   output logic             write_latch_clear,          // Pulse: return to write disable.
   output logic [15:0]      lock_state                  // Lock bit per page, zero is locked.
);

   import spl_pkg::*;

   localparam int PW = $clog2(PROG_CYCLES + 1);  // Width of the cycle counter.

   typedef enum logic [1:0] {SPL_IDLE, SPL_CHECK, SPL_PROG} spl_state_t;

   // ********************************************************************
   // Link domain: frame capture on the serial clock.
   // ********************************************************************

   localparam int SPL_PAGE_BYTES_C = 8;    // Reference bytes per page.

   logic        link_rst;                  // Frame reset: chip select high or system reset.
   logic [2:0]  bit_cnt_q;                 // Bits received in the current byte.
   logic [3:0]  byte_idx_q;                // Index of the current byte in the frame.
   logic [6:0]  shift_q;                   // Partial receive byte.
   logic [7:0]  rx_byte;                   // Byte completed on this edge.
   logic        frame_tog_q;               // Flips once per frame that carries clocks.
   logic [3:0]  frame_len_q;               // Whole bytes in the last frame.
   logic [7:0]  opcode_q;                  // Captured command byte.
   logic [7:0]  addr_q;                    // Captured address byte.
   logic [7:0]  ref_q [SPL_PAGE_BYTES_C];  // Captured reference bytes.
   logic        query_act_q;               // Lock query is returning bytes.
   logic [3:0]  query_ptr_q;               // Page whose lock is being returned.
   logic        so_q;                      // Serial out flop.
   logic        so_oe_n_q;                 // Serial out enable flop, low drives.
   logic [15:0] lock_meta_q;               // Lock bits, first sync stage.
   logic [15:0] lock_s_q;                  // Lock bits, usable in the link domain.
   logic        busy_meta_q;               // Busy, first sync stage.
   logic        busy_s_q;                  // Busy, usable in the link domain.

   // The frame's own chip select ends it, so nothing counts on a clock
   // edge after the last one of a frame.
   assign link_rst = rst | spi_cs_n;
   assign rx_byte  = {shift_q, spi_si};

   // Bit and byte counters, cleared by every deselect.
   always_ff @(posedge spi_sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         bit_cnt_q  <= 3'h0;
         byte_idx_q <= 4'h0;
      end
      else
      begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         // Saturate so that over-long frames stay recognisable.
         if (bit_cnt_q == SPL_LAST_BIT && byte_idx_q != SPL_FRAME_LEN_MAX)
         begin
            byte_idx_q <= byte_idx_q + 4'h1;
         end
      end
   end

   // Serial input shifter; bytes arrive most significant bit first.
   // MSB-first shifting
   always_ff @(posedge spi_sck or posedge rst)
   begin
      if (rst)
      begin
         shift_q <= 7'h00;
      end
      else
      begin
         shift_q <= rx_byte[6:0];
      end
   end

   // Frame capture.  These registers survive deselect on purpose: the
   // system domain reads them after chip select has risen, when the
   // serial clock is still and the words are stable.
   always_ff @(posedge spi_sck or posedge rst)
   begin
      if (rst)
      begin
         frame_tog_q <= 1'b0;
         frame_len_q <= 4'h0;
         opcode_q    <= 8'h00;
         addr_q      <= 8'h00;
         for (int i = 0; i < SPL_PAGE_BYTES_C; i++)
         begin
            ref_q[i] <= 8'h00;
         end
      end
      else if (!busy_s_q)
      begin
         // First edge of a frame announces it to the system domain.
         if (bit_cnt_q == 3'h0 && byte_idx_q == SPL_BYTE_OPCODE)
         begin
            frame_tog_q <= ~frame_tog_q;
            frame_len_q <= 4'h0;
         end
         if (bit_cnt_q == SPL_LAST_BIT)
         begin
            frame_len_q <= (byte_idx_q == SPL_FRAME_LEN_MAX) ? SPL_FRAME_LEN_MAX : byte_idx_q + 4'h1;
            if (byte_idx_q == SPL_BYTE_OPCODE)
            begin
               opcode_q <= rx_byte;
            end
            else if (byte_idx_q == SPL_BYTE_ADDR)
            begin
               addr_q <= rx_byte;
            end
            else if (byte_idx_q < SPL_LOCK_FRAME_LEN)
            begin
               ref_q[3'(byte_idx_q - SPL_FIRST_REF_BYTE)] <= rx_byte;
            end
         end
      end
   end

   // Lock query pointer: starts at the addressed page, then steps one
   // page per returned byte, wrapping after the last page.
   always_ff @(posedge spi_sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         query_act_q <= 1'b0;
         query_ptr_q <= 4'h0;
      end
      else if (bit_cnt_q == SPL_LAST_BIT)
      begin
         if (byte_idx_q == SPL_BYTE_ADDR && opcode_q == SPL_OP_LOCK_QUERY && !busy_s_q)
         begin
            query_act_q <= 1'b1;
            query_ptr_q <= rx_byte[6:3];
         end
         else if (query_act_q)
         begin
            query_ptr_q <= query_ptr_q + 4'h1;
         end
      end
   end

   // Serial output changes on the falling edge so that it is settled
   // before the master samples on the next rising edge.
   always_ff @(negedge spi_sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         so_q      <= 1'b0;
         so_oe_n_q <= 1'b1;
      end
      else
      begin
         so_oe_n_q <= ~query_act_q;
         so_q <= query_act_q && (bit_cnt_q == 3'h0) && lock_s_q[query_ptr_q];
      end
   end

   // Lock bits into the link domain.  The lock bits only change
   // at the end of a programming cycle, when queries are refused anyway,
   // so a plain two-stage sync of the quiet vector is safe.
   always_ff @(posedge spi_sck or posedge rst)
   begin
      if (rst)
      begin
         lock_meta_q <= SPL_LOCK_RESET;
         lock_s_q    <= SPL_LOCK_RESET;
      end
      else
      begin
         lock_meta_q <= lock_state;
         lock_s_q    <= lock_meta_q;
      end
   end

   // Busy into the link domain, restarting from zero at every deselect.
   // A value left from the last frame would otherwise hide the first
   // edge of a new frame after busy has ended; a frame begun while busy
   // is still refused, since busy arrives before its opcode completes.
   always_ff @(posedge spi_sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         busy_meta_q <= 1'b0;
         busy_s_q    <= 1'b0;
      end
      else
      begin
         busy_meta_q <= busy;
         busy_s_q    <= busy_meta_q;
      end
   end

   assign spi_so      = so_q;
   assign spi_so_oe_n = so_oe_n_q;

   // ********************************************************************
   // System domain: synchronisers and frame-end detection.
   // ********************************************************************

   logic cs_meta_q;    // Chip select, first sync stage.
   logic cs_s_q;       // Chip select, synchronised.
   logic cs_prev_q;    // Chip select, one cycle older.
   logic tog_meta_q;   // Frame toggle, first sync stage.
   logic tog_s_q;      // Frame toggle, synchronised.
   logic tog_seen_q;   // Frame toggle last consumed.
   logic wp_meta_q;    // Write protect, first sync stage.
   logic wp_s_q;       // Write protect, synchronised.
   logic frame_end;    // Chip select has just risen.
   logic frame_new;    // That frame carried at least one clock.

   // Pins and the link-domain toggle each pass two flops first.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cs_meta_q  <= 1'b1;
         cs_s_q     <= 1'b1;
         cs_prev_q  <= 1'b1;
         tog_meta_q <= 1'b0;
         tog_s_q    <= 1'b0;
         wp_meta_q  <= 1'b0;
         wp_s_q     <= 1'b0;
      end
      else
      begin
         cs_meta_q  <= spi_cs_n;
         cs_s_q     <= cs_meta_q;
         cs_prev_q  <= cs_s_q;
         tog_meta_q <= frame_tog_q;
         tog_s_q    <= tog_meta_q;
         wp_meta_q  <= wp_n;
         wp_s_q     <= wp_meta_q;
      end
   end

   assign frame_end = cs_s_q & ~cs_prev_q;
   assign frame_new = tog_s_q ^ tog_seen_q;

   // Each frame is consumed once, busy or not, so a refused frame is
   // never executed later.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tog_seen_q <= 1'b0;
      end
      else if (frame_end)
      begin
         tog_seen_q <= tog_s_q;
      end
   end

   // ********************************************************************
   // System domain: command checks.
   // ********************************************************************

   logic       is_lock_cmd;   // Frame holds a lock set or clear opcode.
   logic [3:0] cmd_page;      // Page addressed by the frame.
   logic       guarded;       // Page lies in a guarded block.
   logic       permitted;     // Every enabling condition holds.

   assign is_lock_cmd = (opcode_q == SPL_OP_LOCK_SET) || (opcode_q == SPL_OP_LOCK_CLEAR);
   assign cmd_page = addr_q[6:3];

   // Guard coverage grows from the top page downward.
   always_comb
   begin
      case ({block_guard_bit_high, block_guard_bit_low})
         2'b00:   guarded = 1'b0;
         2'b01:   guarded = (cmd_page >= SPL_GUARD_QUARTER_BASE);
         2'b10:   guarded = (cmd_page >= SPL_GUARD_HALF_BASE);
         default: guarded = 1'b1;
      endcase
   end

   assign permitted = write_latch & wp_s_q & ~guarded & (frame_len_q == SPL_LOCK_FRAME_LEN);

   // ********************************************************************
   // System domain: verification and programming sequence.
   // ********************************************************************

   spl_state_t    state_q;     // Sequence state.
   logic [3:0]    step_q;      // Read and compare step.
   logic [3:0]    page_q;      // Page being worked on.
   logic          cmd_set_q;   // One for lock set, zero for lock clear.
   logic          mismatch_q;  // Some reference bit differed.
   logic          byte_diff;   // Current read byte differs.
   logic [PW-1:0] prog_cnt_q;  // Programming cycle counter.
   logic          rd_en_q;     // Read strobe flop.
   logic [6:0]    rd_addr_q;   // Read address flop.
   logic          busy_q;      // Busy flop.
   logic          wl_clr_q;    // Write latch clear pulse flop.

   // Data for step n was requested two steps earlier.
   assign byte_diff = (page_rd_data != ref_q[3'(step_q - SPL_READ_LATENCY)]);

   // Main sequence: check every byte, then time the programming cycle.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q    <= SPL_IDLE;
         step_q     <= 4'h0;
         page_q     <= 4'h0;
         cmd_set_q  <= 1'b0;
         mismatch_q <= 1'b0;
         prog_cnt_q <= '0;
         busy_q     <= 1'b0;
         wl_clr_q   <= 1'b0;
      end
      else
      begin
         wl_clr_q <= 1'b0;
         case (state_q)
            SPL_IDLE:
            begin
               if (frame_end && frame_new && is_lock_cmd && permitted)
               begin
                  state_q    <= SPL_CHECK;
                  busy_q     <= 1'b1;
                  step_q     <= 4'h0;
                  page_q     <= cmd_page;
                  cmd_set_q  <= (opcode_q == SPL_OP_LOCK_SET);
                  mismatch_q <= 1'b0;
                  wl_clr_q   <= 1'b1;
               end
            end
            SPL_CHECK:
            begin
               step_q <= step_q + 4'h1;
               if (step_q >= SPL_READ_LATENCY)
               begin
                  mismatch_q <= mismatch_q | byte_diff;
               end
               if (step_q == SPL_CHECK_LAST)
               begin
                  if (mismatch_q || byte_diff)
                  begin
                     state_q <= SPL_IDLE;
                     busy_q  <= 1'b0;
                  end
                  else
                  begin
                     state_q    <= SPL_PROG;
                     prog_cnt_q <= '0;
                  end
               end
            end
            SPL_PROG:
            begin
               prog_cnt_q <= prog_cnt_q + PW'(1);
               if (prog_cnt_q == PW'(PROG_CYCLES - 1))
               begin
                  state_q <= SPL_IDLE;
                  busy_q  <= 1'b0;
               end
            end
            default:
            begin
               state_q <= SPL_IDLE;
               busy_q  <= 1'b0;
            end
         endcase
      end
   end

   // Read port toward the data array.  It only ever reads.
   // Page data untouched
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_en_q   <= 1'b0;
         rd_addr_q <= 7'h00;
      end
      else
      begin
         rd_en_q   <= (state_q == SPL_CHECK) && (step_q < SPL_ISSUE_LIMIT);
         rd_addr_q <= {page_q, step_q[2:0]};
      end
   end

   // ********************************************************************
   // System domain: lock memory and success flag.
   // ********************************************************************

   logic [15:0] lock_q;      // One bit per page, zero is locked.
   logic        flag_q;      // Update success flag, low after success.
   logic        prog_done;   // Last cycle of programming.

   assign prog_done = (state_q == SPL_PROG) && (prog_cnt_q == PW'(PROG_CYCLES - 1));

   // Sixteen lock bits
   // The bit changes only at the end of the cycle, so a lost supply
   // midway leaves the old protection in force.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         lock_q <= SPL_LOCK_RESET;
      end
      else if (prog_done)
      begin
         lock_q[page_q] <= ~cmd_set_q;
      end
   end

   // The flag goes high while a cycle runs and low when it succeeds.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         flag_q <= SPL_FLAG_RESET;
      end
      else if (prog_done)
      begin
         flag_q <= 1'b0;
      end
      else if (state_q == SPL_CHECK && step_q == SPL_CHECK_LAST && !(mismatch_q || byte_diff))
      begin
         flag_q <= 1'b1;
      end
   end

   assign lock_state               = lock_q;
   assign lock_update_success_flag = flag_q;
   assign busy                     = busy_q;
   assign write_latch_clear        = wl_clr_q;
   assign page_rd_en               = rd_en_q;
   assign page_rd_addr             = rd_addr_q;

endmodule // spl_page_lock

`default_nettype wire

// File: verilog/spl_pkg.sv
/*
 * Constants shared by the page-lock logic of the serial EEPROM: command
 * opcodes, frame layout, lock memory reset state, block-guard page limits
 * and the lock programming time.
 * Assumes a 40 MHz system clock and an SPI master running mode 0.
 */
`default_nettype none

package spl_pkg;

   // ********************************************************************
   // Command opcodes, sent most significant bit first.
   // ********************************************************************
   localparam logic [7:0] SPL_OP_LOCK_SET   = 8'h22;  // Lock a page.
   localparam logic [7:0] SPL_OP_LOCK_CLEAR = 8'h32;  // Unlock a page.
   localparam logic [7:0] SPL_OP_LOCK_QUERY = 8'h13;  // Read lock bits.

   // ********************************************************************
   // Frame layout, counted in whole bytes from chip select low.
   // ********************************************************************
   localparam logic [3:0] SPL_BYTE_OPCODE     = 4'h0;  // Command byte index.
   localparam logic [3:0] SPL_BYTE_ADDR       = 4'h1;  // Address byte index.
   localparam logic [3:0] SPL_FIRST_REF_BYTE  = 4'h2;  // First reference byte.
   localparam logic [3:0] SPL_LOCK_FRAME_LEN  = 4'ha;  // Opcode, address, eight bytes.
   localparam logic [3:0] SPL_FRAME_LEN_MAX   = 4'hb;  // Saturation point, means too long.
   localparam logic [2:0] SPL_LAST_BIT        = 3'h7;  // Bit count of a byte's last bit.

   // ********************************************************************
   // Lock memory and status reset values.
   // ********************************************************************
   localparam logic [15:0] SPL_LOCK_RESET = 16'hffff;  // All pages unlocked.
   localparam logic        SPL_FLAG_RESET = 1'b1;      // No success reported yet.

   // ********************************************************************
   // Block guard limits: first page covered by each guard setting.
   // ********************************************************************
   localparam logic [3:0] SPL_GUARD_QUARTER_BASE = 4'hc;  // Upper quarter.
   localparam logic [3:0] SPL_GUARD_HALF_BASE    = 4'h8;  // Upper half.

   // ********************************************************************
   // Data read-back timing and lock programming time.
   // ********************************************************************
   localparam logic [3:0] SPL_READ_LATENCY   = 4'h2;     // Issue to usable data.
   localparam logic [3:0] SPL_CHECK_LAST     = 4'h9;     // Last compare step.
   localparam logic [3:0] SPL_ISSUE_LIMIT    = 4'h8;     // Bytes read per page.
   localparam int         SPL_SYS_CLK_NS     = 25;       // System clock period.
   localparam int         SPL_PROG_TIME_NS   = 2500000;  // Typical lock cycle.
   localparam int         SPL_PROG_CYCLES    = SPL_PROG_TIME_NS / SPL_SYS_CLK_NS;

endpackage

`default_nettype wire
